// >>> pkg/pcm_port_pkg.sv
// Purpose: shared constants for the pcm serial word port
// Assumes: system clock at 40 MHz, eight-bit words, sign bit first
// Notes: the decode delay count is derived from a time in ns; the null count is given in cycles
package pcm_port_pkg;
  localparam int WORD_BITS = 8;
  localparam int SIGN_POS = 7;
  localparam int SIG_POS = 0;
  localparam int MAG_BITS = 7;
  localparam int SYS_CLK_KHZ = 40000;
  localparam int DAC_DELAY_NS = 7000;
  localparam int DAC_DELAY_CYC = (DAC_DELAY_NS * SYS_CLK_KHZ) / 1000000;
  localparam int NULL_CYC = 4;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [3:0] BIT_CNT_FULL = 4'h8;
  localparam logic [7:0] WORD_RST = 8'h00;
  localparam logic [6:0] OFFSET_RST = 7'h00;
  typedef enum logic [2:0] {
    CONV_IDLE = 3'b001,
    CONV_NULL = 3'b010,
    CONV_RUN = 3'b100
  } conv_state_t;
endpackage

// >>> hdl/sync3.sv
// Purpose: three-stage synchroniser for pins entering a clock domain
// Assumes: inputs are slow relative to clk_i
// Notes: output moves only once stages two and three agree
`timescale 1ns/1ps
module sync3 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // per-bit agreement, so one bit in flux does not hold the others
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_o <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          sync_o[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule // sync3

// >>> hdl/pcm_port.sv
// Purpose: serial pcm word port with a/b signalling and offset-null sequencing
// Assumes: strobes are synchronous to their own bit clocks; converter is outside
// Notes: bit clocks may stop between frames; nothing here needs an edge then
`timescale 1ns/1ps
// Function
// - received bit 8 steered by route select
// - offset adjust cycle before every conversion
// - offset nulling never touches sign bit
// - first bit taken when strobe, clock high
// - decoded output updates 7 us after word
// - select rise picks output a, fall b
// - transmit lsb from signal input a or b
// - sign, three chord, four step bits
// - data driven only while transmit strobe high
module pcm_port
  import pcm_port_pkg::*;
#(
  parameter int DAC_DELAY = DAC_DELAY_CYC,
  parameter int NULL_LEN = NULL_CYC
) (
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // transmit link
  input wire logic tx_bit_clock_i,
  input wire logic tx_frame_strobe_i,
  input wire logic tx_signal_source_select_i,
  input wire logic signal_a_in_i,
  input wire logic signal_b_in_i,
  output logic tx_data_o,
  output logic tx_data_oe_o,
  // receive link
  input wire logic rx_bit_clock_i,
  input wire logic rx_frame_strobe_i,
  input wire logic rx_data_i,
  input wire logic rx_signal_route_select_i,
  output logic signal_a_out_o,
  output logic signal_b_out_o,
  // converter side
  input wire logic adc_sign_i,
  input wire logic [MAG_BITS-1:0] adc_mag_i,
  output logic null_active_o,
  output logic convert_o,
  output logic [WORD_BITS-1:0] dac_code_o,
  output logic dac_update_o
);
  // ---------------- system domain: offset null then conversion
  conv_state_t state_ff;
  conv_state_t nxt_state;
  logic tx_strobe_sys;
  logic tx_strobe_sys_d_ff;
  logic [7:0] null_cnt_ff;
  logic [MAG_BITS-1:0] offset_ff;
  logic [WORD_BITS-1:0] tx_hold_ff;
  logic [MAG_BITS-1:0] nulled_mag;

  sync3 #(.WIDTH(1)) u_sync_tx_strobe (
    .clk_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .async_i(tx_frame_strobe_i),
    .sync_o(tx_strobe_sys)
  );

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_strobe_sys_d_ff <= 1'b0;
    end else begin
      tx_strobe_sys_d_ff <= tx_strobe_sys;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      CONV_IDLE: begin
        if (tx_strobe_sys && !tx_strobe_sys_d_ff) begin
          nxt_state = CONV_NULL;
        end
      end
      CONV_NULL: begin
        if (null_cnt_ff == 8'(NULL_LEN - 1)) begin
          nxt_state = CONV_RUN;
        end
      end
      CONV_RUN: begin
        nxt_state = CONV_IDLE;
      end
      default: begin
        nxt_state = CONV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= CONV_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      null_cnt_ff <= 8'h00;
    end else if (state_ff == CONV_NULL) begin
      null_cnt_ff <= null_cnt_ff + 8'h01;
    end else begin
      null_cnt_ff <= 8'h00;
    end
  end

  // the trim is magnitude only, so a grounded input keeps a steady sign
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      offset_ff <= OFFSET_RST;
    end else if (state_ff == CONV_NULL && null_cnt_ff == 8'(NULL_LEN - 1)) begin
      offset_ff <= adc_mag_i;
    end
  end

  assign nulled_mag = (adc_mag_i > offset_ff) ? MAG_BITS'(adc_mag_i - offset_ff) : '0;

  // hold changes mid-frame; the tx side loads it at the next frame start,
  // a full frame later, so the word is quasi-static when crossed
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_hold_ff <= WORD_RST;
    end else if (state_ff == CONV_RUN) begin
      tx_hold_ff <= {adc_sign_i, nulled_mag};
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      null_active_o <= 1'b0;
      convert_o <= 1'b0;
    end else begin
      null_active_o <= (nxt_state == CONV_NULL);
      convert_o <= (nxt_state == CONV_RUN);
    end
  end

  // ---------------- transmit domain
  logic tx_sel_sync;
  logic [1:0] tx_sig_sync;
  logic [WORD_BITS-1:0] tx_shift_ff;

  sync3 #(.WIDTH(1)) u_sync_tx_sel (
    .clk_i(tx_bit_clock_i),
    .reset_n_i(reset_n_i),
    .async_i(tx_signal_source_select_i),
    .sync_o(tx_sel_sync)
  );

  // signal pins are foreign; a change settles during the frame before use
  sync3 #(.WIDTH(2)) u_sync_tx_sig (
    .clk_i(tx_bit_clock_i),
    .reset_n_i(reset_n_i),
    .async_i({signal_a_in_i, signal_b_in_i}),
    .sync_o(tx_sig_sync)
  );

  // oe doubles as the in-frame flag: it clears on the strobe fall itself,
  // so a bit clock that stops between frames cannot block the next load
  always_ff @(posedge tx_bit_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_shift_ff <= WORD_RST;
      tx_data_o <= 1'b0;
    end else if (tx_frame_strobe_i && !tx_data_oe_o) begin
      tx_shift_ff <= {tx_hold_ff[WORD_BITS-2:1],
                      tx_sel_sync ? tx_sig_sync[1] : tx_sig_sync[0], 1'b0};
      tx_data_o <= tx_hold_ff[SIGN_POS];
    end else if (tx_frame_strobe_i) begin
      tx_shift_ff <= {tx_shift_ff[WORD_BITS-2:0], 1'b0};
      tx_data_o <= tx_shift_ff[WORD_BITS-1];
    end
  end

  // strobe fall releases the pin at once, even with the bit clock stopped
  always_ff @(posedge tx_bit_clock_i or negedge tx_frame_strobe_i or negedge reset_n_i) begin
    if (!reset_n_i || !tx_frame_strobe_i) begin
      tx_data_oe_o <= 1'b0;
    end else begin
      tx_data_oe_o <= 1'b1;
    end
  end

  // ---------------- receive domain
  logic rx_route_sync;
  logic [3:0] rx_cnt_ff;
  logic [WORD_BITS-1:0] rx_shift_ff;
  logic [WORD_BITS-1:0] rx_word_ff;
  logic rx_done_tgl_ff;

  sync3 #(.WIDTH(1)) u_sync_rx_route (
    .clk_i(rx_bit_clock_i),
    .reset_n_i(reset_n_i),
    .async_i(rx_signal_route_select_i),
    .sync_o(rx_route_sync)
  );

  // strobe fall clears the count, as no bit clock edge may follow it
  always_ff @(posedge rx_bit_clock_i or negedge rx_frame_strobe_i or negedge reset_n_i) begin
    if (!reset_n_i || !rx_frame_strobe_i) begin
      rx_cnt_ff <= BIT_CNT_RST;
    end else if (rx_cnt_ff != BIT_CNT_FULL) begin
      rx_cnt_ff <= rx_cnt_ff + 4'h1;
    end
  end

  // bits past the eighth are ignored if the strobe runs long
  always_ff @(posedge rx_bit_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_shift_ff <= WORD_RST;
    end else if (rx_frame_strobe_i && rx_cnt_ff != BIT_CNT_FULL) begin
      rx_shift_ff <= {rx_shift_ff[WORD_BITS-2:0], rx_data_i};
    end
  end

  // word complete on the eighth edge, so no edge after the strobe is needed
  always_ff @(posedge rx_bit_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_word_ff <= WORD_RST;
      rx_done_tgl_ff <= 1'b0;
      signal_a_out_o <= 1'b0;
      signal_b_out_o <= 1'b0;
    end else if (rx_frame_strobe_i && rx_cnt_ff == BIT_CNT_FULL - 4'h1) begin
      rx_word_ff <= {rx_shift_ff[WORD_BITS-2:0], rx_data_i};
      rx_done_tgl_ff <= ~rx_done_tgl_ff;
      if (rx_route_sync) begin
        signal_a_out_o <= rx_data_i;
      end else begin
        signal_b_out_o <= rx_data_i;
      end
    end
  end

  // ---------------- decoded word back into the system domain
  logic rx_done_sys;
  logic rx_done_sys_d_ff;
  logic dac_wait_ff;
  logic [15:0] dac_cnt_ff;

  sync3 #(.WIDTH(1)) u_sync_rx_done (
    .clk_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .async_i(rx_done_tgl_ff),
    .sync_o(rx_done_sys)
  );

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_done_sys_d_ff <= 1'b0;
      dac_wait_ff <= 1'b0;
      dac_cnt_ff <= 16'h0000;
      dac_code_o <= WORD_RST;
      dac_update_o <= 1'b0;
    end else begin
      rx_done_sys_d_ff <= rx_done_sys;
      dac_update_o <= 1'b0;
      if (rx_done_sys != rx_done_sys_d_ff) begin
        dac_wait_ff <= 1'b1;
        dac_cnt_ff <= 16'h0000;
      end else if (dac_wait_ff && dac_cnt_ff == 16'(DAC_DELAY - 1)) begin
        dac_wait_ff <= 1'b0;
        dac_code_o <= rx_word_ff;
        dac_update_o <= 1'b1;
      end else if (dac_wait_ff) begin
        dac_cnt_ff <= dac_cnt_ff + 16'h0001;
      end
    end
  end
endmodule // pcm_port

// >>> sim/pcm_port_checker.sv
// Purpose: port checks for pcm_port
// Assumes: null phase of 4 cycles
// Notes: routing checked on the receive clock
`timescale 1ns/1ps
module pcm_port_checker (
  // system side
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic tx_frame_strobe_i,
  input wire logic tx_data_oe_o,
  input wire logic null_active_o,
  input wire logic convert_o,
  input wire logic [7:0] dac_code_o,
  input wire logic dac_update_o,
  // receive side
  input wire logic rx_bit_clock_i,
  input wire logic signal_a_out_o,
  input wire logic signal_b_out_o
);
  oe_release_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !tx_frame_strobe_i |-> !tx_data_oe_o)
    else $error("output driven outside frame");
  null_len_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(null_active_o) |-> null_active_o[*4] ##1 !null_active_o)
    else $error("null phase length wrong");
  conv_after_null_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    convert_o |-> $past(null_active_o))
    else $error("conversion without null phase");
  null_excl_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    null_active_o |-> !convert_o)
    else $error("conversion during null phase");
  conv_pulse_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    convert_o |=> !convert_o)
    else $error("convert pulse too long");
  dac_mark_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $changed(dac_code_o) |-> dac_update_o)
    else $error("code changed without update");
  dac_pulse_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    dac_update_o |=> !dac_update_o)
    else $error("update pulse too long");
  one_route_a: assert property (@(posedge rx_bit_clock_i) disable iff (!reset_n_i)
    !($changed(signal_a_out_o) && $changed(signal_b_out_o)))
    else $error("both signal outputs moved");
  cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) convert_o);
  cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) dac_update_o);
  cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) tx_data_oe_o);
endmodule // pcm_port_checker

bind pcm_port pcm_port_checker pcm_port_checker_inst (
  .clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i),
  .tx_frame_strobe_i(tx_frame_strobe_i),
  .tx_data_oe_o(tx_data_oe_o),
  .null_active_o(null_active_o),
  .convert_o(convert_o),
  .dac_code_o(dac_code_o),
  .dac_update_o(dac_update_o),
  .rx_bit_clock_i(rx_bit_clock_i),
  .signal_a_out_o(signal_a_out_o),
  .signal_b_out_o(signal_b_out_o)
);

// >>> sim/pcm_highway_model.sv
// Purpose: highway controller model for both links
// Assumes: 30 ns bit clocks, stopped between frames
// Notes: frame spacing is left to the caller
`timescale 1ns/1ps
module pcm_highway_model (
  // link outputs
  output logic tx_bit_clock_o,
  output logic tx_frame_strobe_o,
  output logic rx_bit_clock_o,
  output logic rx_frame_strobe_o,
  output logic rx_data_o,
  // link inputs
  input wire logic tx_data_i,
  input wire logic tx_data_oe_i
);
  logic [7:0] tx_word;
  logic tx_oe_seen;
  initial begin
    tx_bit_clock_o = 1'b0;
    tx_frame_strobe_o = 1'b0;
    rx_bit_clock_o = 1'b0;
    rx_frame_strobe_o = 1'b0;
    rx_data_o = 1'b1;
  end
  // strobe edges sit in the low phase, clear of clock edges
  task automatic tx_frame();
    tx_oe_seen = 1'b1;
    tx_frame_strobe_o = 1'b1;
    #8;
    repeat (8) begin
      tx_bit_clock_o = 1'b1;
      #15;
      tx_word = {tx_word[6:0], tx_data_i};
      tx_oe_seen = tx_oe_seen & tx_data_oe_i;
      tx_bit_clock_o = 1'b0;
      #15;
    end
    tx_frame_strobe_o = 1'b0;
  endtask
  task automatic rx_frame(input logic [7:0] w, input int nbits);
    rx_data_o = w[7];
    rx_frame_strobe_o = 1'b1;
    #8;
    for (int i = 1; i <= nbits; i++) begin
      rx_bit_clock_o = 1'b1;
      #15;
      rx_bit_clock_o = 1'b0;
      #7;
      if (i < 8) rx_data_o = w[7-i];
      #8;
    end
    rx_frame_strobe_o = 1'b0;
    // hold over: show the inverse so a stale sample cannot pass
    rx_data_o = ~rx_data_o;
  endtask
endmodule // pcm_highway_model

// >>> sim/pcm_port_test.sv
// Purpose: self-checking bench for pcm_port
// Assumes: decode delay shortened to 8 cycles
// Notes: the transmit word is checked one frame late, the receive word after its own frame
`timescale 1ns/1ps
module pcm_port_test;
  import pcm_port_pkg::*;
  localparam int DLY = 8;
  logic clk_sys_i, reset_n_i, tx_clk, tx_stb, rx_clk, rx_stb, rx_data;
  logic tx_sel, rx_sel, sig_a, sig_b, tx_data, tx_oe, out_a, out_b;
  logic adc_sign, null_act, conv, dac_upd;
  logic [MAG_BITS-1:0] adc_mag;
  logic [WORD_BITS-1:0] dac_code;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  pcm_port #(.DAC_DELAY(DLY)) pcm_port_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .tx_bit_clock_i(tx_clk), .tx_frame_strobe_i(tx_stb), .tx_signal_source_select_i(tx_sel),
    .signal_a_in_i(sig_a), .signal_b_in_i(sig_b), .tx_data_o(tx_data), .tx_data_oe_o(tx_oe),
    .rx_bit_clock_i(rx_clk), .rx_frame_strobe_i(rx_stb), .rx_data_i(rx_data),
    .rx_signal_route_select_i(rx_sel), .signal_a_out_o(out_a), .signal_b_out_o(out_b),
    .adc_sign_i(adc_sign), .adc_mag_i(adc_mag), .null_active_o(null_act), .convert_o(conv),
    .dac_code_o(dac_code), .dac_update_o(dac_upd));
  pcm_highway_model pcm_highway_model_inst (.tx_bit_clock_o(tx_clk), .tx_frame_strobe_o(tx_stb),
    .rx_bit_clock_o(rx_clk), .rx_frame_strobe_o(rx_stb), .rx_data_o(rx_data),
    .tx_data_i(tx_data), .tx_data_oe_i(tx_oe));
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic test_tx();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys_i);
      adc_sign = i[0];
      tx_sel = i[1];
      sig_a = i[0];
      sig_b = ~i[0];
      // first frame flushes the previous word and select
      repeat (2) begin
        pcm_highway_model_inst.tx_frame();
        repeat (40) @(negedge clk_sys_i);
      end
      // constant input nulls to zero magnitude; sign passes untouched
      check(pcm_highway_model_inst.tx_word, {i[0], 6'h00, i[1] ? i[0] : ~i[0]},
        "tx word");
      check({6'h00, pcm_highway_model_inst.tx_oe_seen, tx_oe}, 8'h02, "drive window");
    end
    $display("test_tx done");
  endtask
  task automatic test_rx();
    logic [7:0] w;
    int n;
    for (int i = 0; i < 4; i++) begin
      w = i[0] ? 8'hA5 : 8'h3C;
      @(negedge clk_sys_i);
      rx_sel = i[1];
      pcm_highway_model_inst.rx_frame(~w, 8);
      repeat (60) @(negedge clk_sys_i);
      pcm_highway_model_inst.rx_frame(w, 8);
      n = 0;
      while (dac_upd !== 1'b1 && n < 100) begin
        @(negedge clk_sys_i);
        n++;
      end
      check(dac_code, w, "decoded word");
      check({7'h00, i[1] ? out_a : out_b}, {7'h00, w[0]}, "routed bit");
      check({7'h00, n >= DLY && n < 40}, 8'h01, "decode delay");
      repeat (60) @(negedge clk_sys_i);
    end
    $display("test_rx done");
  endtask
  task automatic test_short();
    logic [7:0] keep;
    keep = dac_code;
    pcm_highway_model_inst.rx_frame(~keep, 5);
    repeat (60) @(negedge clk_sys_i);
    check(dac_code, keep, "short frame");
    $display("test_short done");
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    tx_sel = 1'b0;
    rx_sel = 1'b0;
    sig_a = 1'b0;
    sig_b = 1'b0;
    adc_sign = 1'b0;
    adc_mag = 7'h55;
    reset_n_i = 1'b0;
    repeat (10) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    repeat (10) @(negedge clk_sys_i);
    test_tx();
    test_rx();
    test_short();
    conclude();
  end
endmodule // pcm_port_test
